/* rtl/dwv_debug_watch.sv */
// Debug watchpoint, status and vector trap unit with scan access
`timescale 1ns/10ps
module dwv_debug_watch import dwv_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic scan_tck,
  input wire logic scan_tdi,
  input wire logic scan_capture,
  input wire logic scan_shift,
  input wire logic scan_update,
  input wire logic test_reset_n,
  output logic scan_tdo,
  input wire logic [31:0] fetch_addr,
  input wire logic [31:0] fetch_insn,
  input wire logic fetch_valid,
  input wire logic fetch_privilege_flag,
  input wire logic compact_isa_state,
  input wire logic fetch_exception_entry,
  input wire logic [31:0] data_addr,
  input wire logic [31:0] data_value,
  input wire logic data_valid,
  input wire logic data_write,
  input wire logic [1:0] data_size,
  input wire logic data_privilege,
  input wire logic outside_condition_wp_a,
  input wire logic outside_condition_wp_b,
  input wire logic halt_request,
  input wire logic halt_acknowledge,
  input wire logic core_intr_enable,
  input wire logic system_access_done,
  output logic fetch_break_request,
  output logic access_break_request,
  output logic single_step_enable,
  output logic link_condition_latch_out
);
  // ============================================================
  // Pin synchronisers
  logic [12:0] sync_meta;
  logic [12:0] sync_s;
  logic tck_q;
  logic tck_s, tdi_s, cap_s, shf_s, upd_s, trst_s;
  logic ext_a_s, ext_b_s, hreq_s, hack_s, core_intr_enable_s, sdone_s, isa_s;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_meta <= DWV_RST_SYNC;
      sync_s <= DWV_RST_SYNC;
      tck_q <= 1'b0;
    end else begin
      sync_meta <= {scan_tck, scan_tdi, scan_capture, scan_shift,
        scan_update, test_reset_n, outside_condition_wp_a,
        outside_condition_wp_b, halt_request, halt_acknowledge,
        core_intr_enable, system_access_done, compact_isa_state};
      sync_s <= sync_meta;
      tck_q <= sync_s[12];
    end
  end

  assign {tck_s, tdi_s, cap_s, shf_s, upd_s, trst_s, ext_a_s, ext_b_s,
    hreq_s, hack_s, core_intr_enable_s, sdone_s, isa_s} = sync_s;

  // ============================================================
  // Scan chain: data, address, read/write
  logic tck_rise;
  logic [DWV_CHAIN_LEN-1:0] shr;
  logic [4:0] rd_addr;
  logic [31:0] rd_data;
  logic reg_wr;
  logic [4:0] wr_addr;
  logic stat_load;

  assign tck_rise = tck_s && !tck_q;
  assign reg_wr = tck_rise && upd_s && shr[DWV_SC_RW];
  assign wr_addr = shr[DWV_SC_RW-1:DWV_SC_ADDR_LSB];

  always_ff @(posedge clk) begin
    if (reset) begin
      shr <= '0;
      scan_tdo <= 1'b0;
    end else if (tck_rise && cap_s) begin
      shr <= {1'b0, rd_addr, rd_data};
      scan_tdo <= rd_data[0];
    end else if (tck_rise && shf_s) begin
      shr <= {tdi_s, shr[DWV_CHAIN_LEN-1:1]};
      scan_tdo <= shr[1];
    end
  end

  // Read address is latched at update so the next capture returns it
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_addr <= DWV_ADR_DBG_CTRL;
    end else if (tck_rise && upd_s && !shr[DWV_SC_RW]) begin
      rd_addr <= wr_addr;
    end
  end

  // ============================================================
  // Debug control, vector trap and watchpoint storage
  logic [3:0] dbg_ctrl;
  logic [7:0] vec_en;
  logic [31:0] wp_reg [0:1][0:5];
  logic wp_sel_hit;
  logic cval_wr;

  assign wp_sel_hit = (wr_addr[4:3] == DWV_WP0_SEL ||
    wr_addr[4:3] == DWV_WP1_SEL) && wr_addr[2:0] <= DWV_WP_CTRL_MSK;
  assign cval_wr = reg_wr && wp_sel_hit && wr_addr[2:0] == DWV_WP_CTRL_VAL;

  always_ff @(posedge clk) begin
    if (reset) begin
      dbg_ctrl <= DWV_RST_DCTRL;
    end else if (reg_wr && wr_addr == DWV_ADR_DBG_CTRL) begin
      dbg_ctrl <= shr[DWV_W_DCTRL-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      vec_en <= DWV_RST_VEC;
    end else if (reg_wr && wr_addr == DWV_ADR_VEC_TRAP) begin
      vec_en <= shr[DWV_W_VEC-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int w = 0; w < 2; w++) begin
        for (int i = 0; i < 6; i++) begin
          wp_reg[w][i] <= DWV_RST_WORD;
        end
      end
    end else if (reg_wr && wp_sel_hit) begin
      wp_reg[wr_addr[4]][wr_addr[2:0]] <= shr[31:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      single_step_enable <= 1'b0;
    end else begin
      single_step_enable <= dbg_ctrl[DWV_STEP_BIT];
    end
  end

  // ============================================================
  // Status snapshot
  logic [4:0] stat;
  logic core_intr_enable_gen;

  // Interrupts read as disabled while the core sits in debug state
  assign core_intr_enable_gen = core_intr_enable_s && !hack_s;
  assign stat_load = (reg_wr && wr_addr == DWV_ADR_DBG_STAT) ||
    (tck_rise && cap_s && rd_addr == DWV_ADR_DBG_STAT);

  always_ff @(posedge clk) begin
    if (reset) begin
      stat <= DWV_RST_STAT;
    end else if (stat_load) begin
      stat <= {isa_s, sdone_s, core_intr_enable_gen, hack_s,
        hreq_s};
    end
  end

  // Capture needs the fresh snapshot, so status reads bypass the flop
  always_comb begin
    rd_data = 32'h0;
    if (rd_addr == DWV_ADR_DBG_CTRL) begin
      rd_data[DWV_W_DCTRL-1:0] = dbg_ctrl;
    end else if (rd_addr == DWV_ADR_DBG_STAT) begin
      rd_data[DWV_W_STAT-1:0] = {isa_s, sdone_s, core_intr_enable_gen, hack_s,
        hreq_s};
    end else if (rd_addr == DWV_ADR_VEC_TRAP) begin
      rd_data[DWV_W_VEC-1:0] = vec_en;
    end else if ((rd_addr[4:3] == DWV_WP0_SEL ||
        rd_addr[4:3] == DWV_WP1_SEL) && rd_addr[2:0] <= DWV_WP_CTRL_MSK) begin
      rd_data = wp_reg[rd_addr[4]][rd_addr[2:0]];
      if (rd_addr[2:0] == DWV_WP_CTRL_VAL) begin
        rd_data[31:DWV_W_CVAL] = '0;
      end else if (rd_addr[2:0] == DWV_WP_CTRL_MSK) begin
        rd_data[31:DWV_W_CMSK] = '0;
      end
    end
  end

  // ============================================================
  // Watchpoint comparators
  dwv_wp_if wp_bus[2] ();
  logic [1:0] wp_ac_hit, wp_d_hit, wp_match, wp_mode, wp_en;
  logic [1:0] wp_ext;
  logic link_latch;

  assign wp_ext = {ext_b_s, ext_a_s};

  genvar gw;
  generate
    for (gw = 0; gw < 2; gw++) begin : g_wp
      logic range_in;
      logic chain_in;
      assign wp_mode[gw] = wp_reg[gw][DWV_WP_CTRL_VAL][DWV_CB_MODE];
      assign wp_en[gw] = wp_reg[gw][DWV_WP_CTRL_VAL][DWV_CB_EN];
      // Second watchpoint has nothing feeding its chain and range inputs
      assign range_in = (gw == 0) ? wp_match[1] : 1'b0;
      assign chain_in = (gw == 0) ? link_latch : 1'b0;
      assign wp_bus[gw].addr = wp_mode[gw] ? data_addr : fetch_addr;
      assign wp_bus[gw].data = wp_mode[gw] ? data_value : fetch_insn;
      assign wp_bus[gw].valid = wp_mode[gw] ? data_valid : fetch_valid;
      // Unused instruction-mode bits 2 and 0 compare against zero
      assign wp_bus[gw].ctrl = wp_mode[gw] ?
        {range_in, chain_in, wp_ext[gw], data_privilege, 1'b1,
         data_size, data_write} :
        {range_in, chain_in, wp_ext[gw], fetch_privilege_flag, 1'b0,
         1'b0, compact_isa_state, 1'b0};
      dwv_watchpoint u_wp (
        .bus(wp_bus[gw]),
        .addr_val(wp_reg[gw][DWV_WP_ADDR_VAL]),
        .addr_msk(wp_reg[gw][DWV_WP_ADDR_MSK]),
        .data_val(wp_reg[gw][DWV_WP_DATA_VAL]),
        .data_msk(wp_reg[gw][DWV_WP_DATA_MSK]),
        .ctrl_val(wp_reg[gw][DWV_WP_CTRL_VAL][DWV_W_CVAL-1:0]),
        .ctrl_msk(wp_reg[gw][DWV_WP_CTRL_MSK][DWV_W_CMSK-1:0]),
        .addr_ctrl_hit(wp_ac_hit[gw]),
        .data_hit(wp_d_hit[gw]),
        .match(wp_match[gw])
      );
    end
  endgenerate

  // Clear beats a load in the same cycle
  always_ff @(posedge clk) begin
    if (reset || !trst_s || cval_wr) begin
      link_latch <= 1'b0;
    end else if (wp_ac_hit[1]) begin
      link_latch <= wp_d_hit[1];
    end
  end

  assign link_condition_latch_out = link_latch;

  // ============================================================
  // Break requests
  logic vc_hit;
  logic wp_ibrk, wp_dbrk;

  dwv_vector_catch u_vc (
    .enables(vec_en),
    .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid),
    .exception_entry(fetch_exception_entry),
    .hit(vc_hit)
  );

  assign wp_ibrk = |(wp_match & wp_en & ~wp_mode);
  assign wp_dbrk = |(wp_match & wp_en & wp_mode);

  always_ff @(posedge clk) begin
    if (reset) begin
      fetch_break_request <= 1'b0;
      access_break_request <= 1'b0;
    end else begin
      fetch_break_request <= wp_ibrk || vc_hit;
      access_break_request <= wp_dbrk;
    end
  end

  // ============================================================
  // Checks
  sequence seq_ctrl_write;
    reg_wr && wr_addr == DWV_ADR_DBG_CTRL;
  endsequence

  sequence seq_step_follow;
    dbg_ctrl == $past(shr[3:0]) ##1
      single_step_enable == $past(dbg_ctrl[DWV_STEP_BIT]);
  endsequence

  chk_step_write_path: assert property (
    @(posedge clk) disable iff (reset)
    seq_ctrl_write |=> seq_step_follow)
    else $error("debug control write did not reach step enable");

  chk_chain_clear_wr: assert property (
    @(posedge clk) disable iff (reset)
    (cval_wr || !trst_s) |=> !link_condition_latch_out)
    else $error("chain latch not cleared");

  chk_chain_load: assert property (
    @(posedge clk) disable iff (reset)
    (wp_ac_hit[1] && trst_s && !cval_wr) |=>
      link_condition_latch_out == $past(wp_d_hit[1]))
    else $error("chain latch did not capture data hit");

  chk_enable_gate: assert property (
    @(posedge clk) disable iff (reset)
    (!(|wp_en) && !vc_hit) |=> !fetch_break_request && !access_break_request)
    else $error("break raised with enable bits clear");

  chk_vec_entry_only: assert property (
    @(posedge clk) disable iff (reset)
    (!fetch_exception_entry && !wp_ibrk) |=> !fetch_break_request)
    else $error("vector trap fired outside exception entry");

  chk_soft_trap_fetch: assert property (
    @(posedge clk) disable iff (reset)
    (vec_en[2] && fetch_valid && fetch_exception_entry &&
      fetch_addr == 32'h8) |=> fetch_break_request)
    else $error("soft trap vector fetch not caught");

  chk_priv_compare: assert property (
    @(posedge clk) disable iff (reset)
    (!wp_mode[0] && !wp_reg[0][DWV_WP_CTRL_MSK][DWV_CB_PRIV] &&
      fetch_privilege_flag != wp_reg[0][DWV_WP_CTRL_VAL][DWV_CB_PRIV])
      |-> !wp_match[0])
    else $error("privilege mismatch still matched");

  chk_isa_compare: assert property (
    @(posedge clk) disable iff (reset)
    (!wp_mode[1] && !wp_reg[1][DWV_WP_CTRL_MSK][DWV_CB_ISA] &&
      compact_isa_state != wp_reg[1][DWV_WP_CTRL_VAL][DWV_CB_ISA])
      |-> !wp_match[1])
    else $error("instruction set state mismatch still matched");

  chk_status_sync: assert property (
    @(posedge clk) disable iff (reset)
    stat_load |=> stat[1:0] == $past({halt_acknowledge, halt_request}, 3))
    else $error("status did not show synchronised halt signals");

  // Range is control bit 7 of both value and mask
  chk_range_couple: assert property (
    @(posedge clk) disable iff (reset)
    (!wp_reg[0][DWV_WP_CTRL_MSK][DWV_W_CMSK-1] && !wp_match[1] &&
      wp_reg[0][DWV_WP_CTRL_VAL][DWV_W_CMSK-1]) |-> !wp_match[0])
    else $error("range input ignored by first watchpoint");

  chk_access_break: assert property (
    @(posedge clk) disable iff (reset)
    (wp_match[1] && wp_mode[1] && wp_en[1]) |=> access_break_request)
    else $error("enabled data watchpoint raised no break");

  chk_data_mode_off: assert property (
    @(posedge clk) disable iff (reset)
    (!wp_mode[0] && !wp_mode[1]) |=> !access_break_request)
    else $error("data break raised in instruction mode");

  chk_rsvd_vec_quiet: assert property (
    @(posedge clk) disable iff (reset)
    (fetch_addr == 32'(DWV_VEC_RSVD) * DWV_VEC_STRIDE && !wp_ibrk) |=>
      !fetch_break_request)
    else $error("reserved vector slot raised a break");

  chk_tdo_capture: assert property (
    @(posedge clk) disable iff (reset)
    (tck_rise && cap_s) |=> scan_tdo == $past(rd_data[0]))
    else $error("capture did not present read data bit 0");

  chk_status_top: assert property (
    @(posedge clk) disable iff (reset)
    stat_load |=> stat[4:3] ==
      $past({compact_isa_state, system_access_done}, 3))
    else $error("status did not show access done and isa state");
endmodule

/* rtl/dwv_pkg.sv */
// Constants for the debug watchpoint and vector trap unit
// ============================================================
// Summary of operation
// - Control bit 3 low selects the instruction buses for comparison.
// - In instruction mode, control bit 1 compares with the compact instruction-set state.
// - Control bit 4 compares with the fetch privilege signal in instruction mode, data privilege in data mode.
// - Each watchpoint has its own outside condition input.
// - Watchpoint 1 address/control hit loads its data hit into chain latch.
// - Chain latch clears on control value write or test reset low.
// - Watchpoint 1 match drives watchpoint 0 range input.
// - Watchpoint break request only raised when enable bit 8 is set.
// - Enable bit exists only in the value register and is never masked.
// - Debug control is four bits; bit 3 enables single stepping.
// - Five-bit status updates on write access, returns on read access.
// - Status bits 0 and 1 show synchronised halt request and acknowledge.
// - Status bit 3 shows synchronised system access done.
// - Status bit 4 shows the compact instruction-set state.
// - Vector trap register holds eight enables, bit 5 reserved.
// - An enabled trapped exception acts like a breakpoint on its vector.
// - Soft trap bit 2 catches the fetch from 0x8 and raises break.
// - Vector trapping uses no watchpoint comparator.
// - Only vector fetches during exception entry are trapped.
// - A mask bit of one excludes its value bit from comparison, except control mask bit 3.
package dwv_pkg;
  // ============================================================
  // Scan chain layout
  localparam int DWV_CHAIN_LEN = 38;
  localparam int DWV_SC_ADDR_LSB = 32;
  localparam int DWV_SC_RW = 37;
  // ============================================================
  // Register addresses
  localparam logic [4:0] DWV_ADR_DBG_CTRL = 5'h00;
  localparam logic [4:0] DWV_ADR_DBG_STAT = 5'h01;
  localparam logic [4:0] DWV_ADR_VEC_TRAP = 5'h02;
  localparam logic [1:0] DWV_WP0_SEL = 2'h1;
  localparam logic [1:0] DWV_WP1_SEL = 2'h2;
  localparam logic [2:0] DWV_WP_ADDR_VAL = 3'h0;
  localparam logic [2:0] DWV_WP_ADDR_MSK = 3'h1;
  localparam logic [2:0] DWV_WP_DATA_VAL = 3'h2;
  localparam logic [2:0] DWV_WP_DATA_MSK = 3'h3;
  localparam logic [2:0] DWV_WP_CTRL_VAL = 3'h4;
  localparam logic [2:0] DWV_WP_CTRL_MSK = 3'h5;
  // ============================================================
  // Field positions
  localparam int DWV_CB_ISA = 1;
  localparam int DWV_CB_MODE = 3;
  localparam int DWV_CB_PRIV = 4;
  localparam int DWV_CB_EN = 8;
  localparam logic [7:0] DWV_CMSK_KEEP = 8'hf7;
  localparam int DWV_STEP_BIT = 3;
  localparam int DWV_VEC_RSVD = 5;
  localparam logic [31:0] DWV_VEC_STRIDE = 32'h4;
  // ============================================================
  // Widths and reset values
  localparam int DWV_W_CVAL = 9;
  localparam int DWV_W_CMSK = 8;
  localparam int DWV_W_DCTRL = 4;
  localparam int DWV_W_STAT = 5;
  localparam int DWV_W_VEC = 8;
  localparam logic [31:0] DWV_RST_WORD = 32'h0;
  localparam logic [3:0] DWV_RST_DCTRL = 4'h0;
  localparam logic [4:0] DWV_RST_STAT = 5'h0;
  localparam logic [7:0] DWV_RST_VEC = 8'h00;
  localparam logic [12:0] DWV_RST_SYNC = 13'h0000;
endpackage

/* rtl/dwv_vector_catch.sv */
// Exception vector fetch trap, separate from the comparators
`timescale 1ns/10ps
module dwv_vector_catch import dwv_pkg::*; (
  input wire logic [7:0] enables,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic exception_entry,
  output logic hit
);
  logic [7:0] vec_hit;

  genvar gv;
  generate
    for (gv = 0; gv < DWV_W_VEC; gv++) begin : g_vec
      if (gv == DWV_VEC_RSVD) begin : g_rsvd
        assign vec_hit[gv] = 1'b0;
      end else begin : g_live
        // Ordinary branches into the table are ignored
        assign vec_hit[gv] = enables[gv] && fetch_valid &&
          exception_entry &&
          (fetch_addr == 32'(gv) * DWV_VEC_STRIDE);
      end
    end
  endgenerate

  assign hit = |vec_hit;
endmodule

/* rtl/dwv_watchpoint.sv */
// One masked watchpoint comparator
`timescale 1ns/10ps
module dwv_watchpoint import dwv_pkg::*; (
  dwv_wp_if.wp bus,
  input wire logic [31:0] addr_val,
  input wire logic [31:0] addr_msk,
  input wire logic [31:0] data_val,
  input wire logic [31:0] data_msk,
  input wire logic [8:0] ctrl_val,
  input wire logic [7:0] ctrl_msk,
  output logic addr_ctrl_hit,
  output logic data_hit,
  output logic match
);
  logic [7:0] eff_cmsk;
  logic addr_eq;
  logic ctrl_eq;

  // Mode bit never masked, so a data-mode entry never fires on fetches
  assign eff_cmsk = ctrl_msk & DWV_CMSK_KEEP;
  assign addr_eq = ((bus.addr ^ addr_val) & ~addr_msk) == 32'h0;
  assign ctrl_eq = ((bus.ctrl ^ ctrl_val[7:0]) & ~eff_cmsk) == 8'h00;
  assign addr_ctrl_hit = bus.valid && addr_eq && ctrl_eq;
  assign data_hit = ((bus.data ^ data_val) & ~data_msk) == 32'h0;
  assign match = addr_ctrl_hit && data_hit;
endmodule

/* rtl/dwv_wp_if.sv */
// Bus view presented to one watchpoint comparator
`timescale 1ns/10ps
interface dwv_wp_if;
  logic [31:0] addr;
  logic [31:0] data;
  logic [7:0] ctrl;
  logic valid;
  modport src (output addr, output data, output ctrl, output valid);
  modport wp (input addr, input data, input ctrl, input valid);
endinterface

/* verif/dwv_debug_watch_bench.sv */
// Self-checking bench for the debug watch and vector trap unit
`timescale 1ns/10ps
module dwv_debug_watch_bench import dwv_pkg::*; ;
  // Row flags are {privilege, compact isa, outside cond, entry, break}
  typedef struct packed {
    logic [31:0] adr;
    logic [4:0] f;
  } dwv_row_t;

  logic clk, reset, test_reset_n;
  logic scan_tck, scan_tdi, scan_capture, scan_shift, scan_update;
  logic scan_tdo;
  logic [31:0] fetch_addr, fetch_insn, data_addr, data_value, rd;
  logic fetch_valid, fetch_privilege_flag, compact_isa_state;
  logic fetch_exception_entry, data_valid, data_write, data_privilege;
  logic [1:0] data_size;
  logic outside_condition_wp_a, outside_condition_wp_b;
  logic halt_request, halt_acknowledge, core_intr_enable;
  logic system_access_done, fetch_break_request, access_break_request;
  logic single_step_enable, link_condition_latch_out;
  int errors = 0;
  int total_checks = 0;
  dwv_row_t rows [0:13];

  dwv_debug_watch dwv_debug_watch_inst (.clk(clk), .reset(reset),
    .scan_tck(scan_tck), .scan_tdi(scan_tdi),
    .scan_capture(scan_capture), .scan_shift(scan_shift),
    .scan_update(scan_update), .test_reset_n(test_reset_n),
    .scan_tdo(scan_tdo), .fetch_addr(fetch_addr),
    .fetch_insn(fetch_insn), .fetch_valid(fetch_valid),
    .fetch_privilege_flag(fetch_privilege_flag),
    .compact_isa_state(compact_isa_state),
    .fetch_exception_entry(fetch_exception_entry),
    .data_addr(data_addr), .data_value(data_value),
    .data_valid(data_valid), .data_write(data_write),
    .data_size(data_size), .data_privilege(data_privilege),
    .outside_condition_wp_a(outside_condition_wp_a),
    .outside_condition_wp_b(outside_condition_wp_b),
    .halt_request(halt_request), .halt_acknowledge(halt_acknowledge),
    .core_intr_enable(core_intr_enable),
    .system_access_done(system_access_done),
    .fetch_break_request(fetch_break_request),
    .access_break_request(access_break_request),
    .single_step_enable(single_step_enable),
    .link_condition_latch_out(link_condition_latch_out));

  dwv_scan_host dwv_scan_host_inst (.clk(clk), .scan_tck(scan_tck),
    .scan_tdi(scan_tdi), .scan_capture(scan_capture),
    .scan_shift(scan_shift), .scan_update(scan_update),
    .scan_tdo(scan_tdo));

  // ============================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    give_verdict();
  end

  // ============================================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic rd_check(input logic [4:0] a, input string n,
      input logic [31:0] e);
    dwv_scan_host_inst.read_reg(a, rd);
    check(n, rd, e);
  endtask

  task automatic wp(input logic [1:0] s, input logic [2:0] fld,
      input logic [31:0] d);
    dwv_scan_host_inst.frame(1'b1, {s, fld}, d);
  endtask

  // One fetch cycle; the outside condition settles through its sync first
  task automatic run_fetch(input dwv_row_t r);
    @(negedge clk);
    outside_condition_wp_a = r.f[2];
    repeat (3) @(negedge clk);
    fetch_addr = r.adr;
    fetch_privilege_flag = r.f[4];
    compact_isa_state = r.f[3];
    fetch_exception_entry = r.f[1];
    fetch_valid = 1'b1;
    @(negedge clk);
    check("fetch_break_request", {31'h0, fetch_break_request},
      {31'h0, r.f[0]});
    fetch_valid = 1'b0;
    fetch_exception_entry = 1'b0;
    @(negedge clk);
    check("break released", {31'h0, fetch_break_request}, 32'h0);
  endtask

  // ============================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    test_reset_n = 1'b1;
    {fetch_addr, fetch_insn, data_addr, data_value} = '0;
    {fetch_valid, fetch_privilege_flag, compact_isa_state} = '0;
    {fetch_exception_entry, data_valid, data_write, data_privilege} = '0;
    data_size = 2'h0;
    {outside_condition_wp_a, outside_condition_wp_b} = '0;
    {halt_request, halt_acknowledge, core_intr_enable} = '0;
    system_access_done = 1'b0;
    rows = '{'{32'h100, 5'b10101}, '{32'h100, 5'b00100},
      '{32'h100, 5'b11101}, '{32'h100, 5'b10000},
      '{32'h104, 5'b10100}, '{32'h008, 5'b10100},
      '{32'h000, 5'b10111}, '{32'h004, 5'b10111},
      '{32'h008, 5'b10111}, '{32'h00c, 5'b10111},
      '{32'h010, 5'b10111}, '{32'h014, 5'b10110},
      '{32'h018, 5'b10111}, '{32'h01c, 5'b10111}};
    repeat (3) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    rd_check(DWV_ADR_DBG_CTRL, "debug_control reset", 32'h0);
    rd_check(DWV_ADR_VEC_TRAP, "vector reset", 32'h0);
    dwv_scan_host_inst.frame(1'b1, DWV_ADR_DBG_CTRL, 32'h8);
    check("single step", {31'h0, single_step_enable}, 32'h1);
    rd_check(DWV_ADR_DBG_CTRL, "debug_control", 32'h8);
    // Status sources
    halt_request = 1'b1;
    core_intr_enable = 1'b1;
    system_access_done = 1'b1;
    compact_isa_state = 1'b1;
    rd_check(DWV_ADR_DBG_STAT, "status", 32'h1d);
    halt_acknowledge = 1'b1;
    dwv_scan_host_inst.frame(1'b1, DWV_ADR_DBG_STAT, 32'h0);
    rd_check(DWV_ADR_DBG_STAT, "status ack", 32'h1b);
    {halt_request, halt_acknowledge, core_intr_enable} = '0;
    system_access_done = 1'b0;
    // Unmapped place takes no write and reads zero
    dwv_scan_host_inst.frame(1'b1, 5'h1f, 32'hffffffff);
    rd_check(5'h1f, "unmapped", 32'h0);
    // Watchpoint 0 on fetch 0x100, privileged, outside condition high
    wp(DWV_WP0_SEL, DWV_WP_ADDR_VAL, 32'h100);
    wp(DWV_WP0_SEL, DWV_WP_DATA_MSK, 32'hffffffff);
    wp(DWV_WP0_SEL, DWV_WP_CTRL_VAL, 32'h130);
    wp(DWV_WP0_SEL, DWV_WP_CTRL_MSK, 32'hc7);
    dwv_scan_host_inst.frame(1'b1, DWV_ADR_VEC_TRAP, 32'hff);
    rd_check(DWV_ADR_VEC_TRAP, "vector trap", 32'hff);
    for (int i = 0; i < 14; i++) begin
      run_fetch(rows[i]);
    end
    // Enable bit clear: same match, no request
    wp(DWV_WP0_SEL, DWV_WP_CTRL_VAL, 32'h030);
    run_fetch('{32'h100, 5'b10100});
    // Compact isa bit compared once unmasked
    wp(DWV_WP0_SEL, DWV_WP_CTRL_VAL, 32'h130);
    wp(DWV_WP0_SEL, DWV_WP_CTRL_MSK, 32'hc5);
    run_fetch('{32'h100, 5'b11100});
    run_fetch('{32'h100, 5'b10101});
    // Watchpoint 1 on 0x100 with instruction 0xabcd; couple range
    wp(DWV_WP1_SEL, DWV_WP_ADDR_VAL, 32'h100);
    wp(DWV_WP1_SEL, DWV_WP_DATA_VAL, 32'habcd);
    wp(DWV_WP1_SEL, DWV_WP_CTRL_MSK, 32'hff);
    wp(DWV_WP0_SEL, DWV_WP_CTRL_VAL, 32'h1b0);
    wp(DWV_WP0_SEL, DWV_WP_CTRL_MSK, 32'h45);
    run_fetch('{32'h100, 5'b10100});
    check("chain miss", {31'h0, link_condition_latch_out}, 32'h0);
    fetch_insn = 32'habcd;
    run_fetch('{32'h100, 5'b10101});
    check("chain hit", {31'h0, link_condition_latch_out}, 32'h1);
    wp(DWV_WP1_SEL, DWV_WP_CTRL_VAL, 32'h0);
    check("chain write", {31'h0, link_condition_latch_out}, 32'h0);
    run_fetch('{32'h100, 5'b10101});
    test_reset_n = 1'b0;
    repeat (4) @(negedge clk);
    check("chain trst", {31'h0, link_condition_latch_out}, 32'h0);
    test_reset_n = 1'b1;
    // Data bus traffic ignored while in instruction mode
    data_addr = 32'h100;
    data_value = 32'habcd;
    data_size = 2'h2;
    {data_valid, data_write, data_privilege} = 3'b111;
    repeat (3) @(negedge clk);
    check("data ignored", {30'h0, fetch_break_request,
      access_break_request}, 32'h0);
    data_valid = 1'b0;
    // Watchpoint 1 in data mode, enabled, on the same traffic
    wp(DWV_WP1_SEL, DWV_WP_CTRL_VAL, 32'h108);
    data_valid = 1'b1;
    @(negedge clk);
    check("data break", {30'h0, fetch_break_request,
      access_break_request}, 32'h1);
    data_valid = 1'b0;
    @(negedge clk);
    check("data break released", {31'h0, access_break_request},
      32'h0);
    give_verdict();
  end
endmodule

/* verif/dwv_scan_host.sv */
// Debugger-side model that drives the scan pins of the unit
`timescale 1ns/10ps
module dwv_scan_host (
  input wire logic clk,
  output logic scan_tck,
  output logic scan_tdi,
  output logic scan_capture,
  output logic scan_shift,
  output logic scan_update,
  input wire logic scan_tdo
);
  // ============================================================
  // Idle pins
  initial begin
    scan_tck = 1'b0;
    scan_tdi = 1'b0;
    scan_capture = 1'b0;
    scan_shift = 1'b0;
    scan_update = 1'b0;
  end

  // ============================================================
  // One scan clock period
  // Each level is held five system clocks so the pin syncs see it
  task automatic tck_cycle(input logic cap, input logic sh,
      input logic upd, input logic bit_in);
    @(negedge clk);
    scan_capture = cap;
    scan_shift = sh;
    scan_update = upd;
    scan_tdi = bit_in;
    repeat (2) @(negedge clk);
    scan_tck = 1'b1;
    repeat (5) @(negedge clk);
    scan_tck = 1'b0;
    repeat (5) @(negedge clk);
    // Released data line flips so a stale bit can never pass as good
    scan_tdi = ~bit_in;
    scan_capture = 1'b0;
    scan_shift = 1'b0;
    scan_update = 1'b0;
  endtask

  // ============================================================
  // Whole frames, data bit 0 first and the write flag last
  task automatic frame(input logic rw, input logic [4:0] adr,
      input logic [31:0] dat);
    logic [37:0] word;
    word = {rw, adr, dat};
    for (int i = 0; i < 38; i++) begin
      tck_cycle(1'b0, 1'b1, 1'b0, word[i]);
    end
    tck_cycle(1'b0, 1'b0, 1'b1, 1'b0);
  endtask

  // Read: select the register, capture it, then shift the data out
  task automatic read_reg(input logic [4:0] adr, output logic [31:0] dat);
    frame(1'b0, adr, 32'h0);
    tck_cycle(1'b1, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 32; i++) begin
      dat[i] = scan_tdo;
      tck_cycle(1'b0, 1'b1, 1'b0, 1'b0);
    end
  endtask
endmodule
